/* File: pkg/tfa_consts.svh */
// Purpose: named offsets, reset values, field positions and timing for the alert logic
// Assumes: included by bare name, definitions only
// Notes: temperatures are 8-bit two's complement, one degree per count
`ifndef TFA_CONSTS_SVH
`define TFA_CONSTS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TFA_ADR_STAT1 8'h02
`define TFA_ADR_CFG1 8'h03
`define TFA_ADR_LHI 8'h05
`define TFA_ADR_LLO 8'h06
`define TFA_ADR_RHI 8'h07
`define TFA_ADR_RLO 8'h08
`define TFA_ADR_MASK1 8'h16
`define TFA_ADR_ROT 8'h19
`define TFA_ADR_STAT2 8'h1A
`define TFA_ADR_MASK2 8'h1B
`define TFA_ADR_CFG2 8'h20
`define TFA_ADR_HYST 8'h21
`define TFA_ADR_LOT 8'h22
`define TFA_ADR_TACHCFG 8'h31
`define TFA_ADR_TLIM_LO 8'h48
`define TFA_ADR_TLIM_HI 8'h49

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TFA_RST_HI 8'h55
`define TFA_RST_LO 8'h00
`define TFA_RST_OT 8'h64
`define TFA_RST_HYST 8'h0A
`define TFA_RST_CFG1 8'h00
`define TFA_RST_CFG2 8'h20
`define TFA_RST_MASK 8'h00
`define TFA_RST_TLIM 8'hFF
`define TFA_RST_TACHCFG 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TFA_B1_BUSY 7
`define TFA_B1_LOCAL 6
`define TFA_B1_SUMMARY 5
`define TFA_B1_RHI 4
`define TFA_B1_RLO 3
`define TFA_B1_FAULT 2
`define TFA_B1_ROT 1
`define TFA_B1_FAN 0
`define TFA_B2_STALL 7
`define TFA_B2_THERM 6
`define TFA_B2_LOT 4
`define TFA_CFG2_THERM_MODE 7
`define TFA_CFG2_FULL 5
`define TFA_CFG2_LUTMAX 4
`define TFA_CFG1_FQ 1:0
`define TFA_TACHCFG_PER 3:2
`define TFA_ALERTABLE1 8'h5B
`define TFA_USED2 8'hD0

// ---------------------------------------------------------------
// bus and timing
// ---------------------------------------------------------------
`define TFA_ARA_ADDR 7'h0C
`define TFA_BYTE_BITS 4'h8
`define TFA_FQ_MAX 3'h4
`define TFA_CLK_MHZ 200
`define TFA_STALL_BASE_US 100000

`endif

/* File: pkg/tfa_pkg.sv */
// Purpose: types and shared arithmetic for the alert logic
// Assumes: temperatures are 8-bit two's complement
// Notes: comparisons are signed; hysteresis limit kept at 9 bits
package tfa_pkg;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_PTR, BUS_WDATA, BUS_ACK, BUS_TX, BUS_TXACK
  } tfa_bus_t;

  typedef struct packed {
    tfa_bus_t st;
    tfa_bus_t after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic ara;
    logic sda_oe;
    logic macked;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [7:0] cfg1;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
    logic [7:0] mask1;
    logic [7:0] rot;
    logic [7:0] mask2;
    logic [7:0] cfg2;
    logic [7:0] hyst;
    logic [7:0] lot;
    logic [7:0] tachcfg;
    logic [7:0] tlim_lo;
    logic [7:0] tlim_hi;
    logic [5:0] cond;
    logic [4:0][2:0] fq;
    logic [7:0] st1;
    logic [7:0] st2;
    logic alert;
    logic th_loc;
    logic th_rem;
    logic pin_oe;
    logic fan_full;
    logic fan_lut;
  } tfa_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [31:0] cnt;
    logic stalled;
  } tfa_stall_t;

  function automatic logic tfa_gt(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) > $signed(b);
  endfunction

  function automatic logic tfa_le(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) <= $signed(b);
  endfunction

  // release point of the over-temperature output, limit minus hysteresis
  function automatic logic tfa_at_release(input logic [7:0] t, input logic [7:0] lim,
                                          input logic [7:0] hy);
    logic [8:0] rel;
    rel = {lim[7], lim} - {1'b0, hy};
    return $signed({t[7], t}) <= $signed(rel);
  endfunction

endpackage

/* File: pkg/tfa_tach_if.sv */
// Purpose: carries tach period selection and stall state between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface tfa_tach_if;
  logic [1:0] periods;
  logic stalled;
  modport ctl (output periods, input stalled);
  modport mon (input periods, output stalled);
endinterface

/* File: hdl/tfa_stall.sv */
// Purpose: fan stall watchdog on the tach pin
// Assumes: tach pin asynchronous to the core clock
// Notes: timeout is the base window times 1, 2, 4 or 8 tach periods
`timescale 1ns/1ps
module tfa_stall
  import tfa_pkg::*;
#(
  parameter int unsigned BASE_CYC = 1000
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tach,
  tfa_tach_if.mon tach
);

  tfa_stall_t q;
  tfa_stall_t d;
  logic [31:0] lim;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    lim = BASE_CYC[31:0] << tach.periods;
    d.s1 = i_tach;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 && !q.s3) begin
      d.cnt = 32'h0;
      d.stalled = 1'b0;
    end else if (q.cnt >= lim - 32'h1) begin
      d.stalled = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tach.stalled = q.stalled;

endmodule

/* File: hdl/tfa_top.sv */
// Purpose: status, mask, alert and over-temperature logic behind an SMBus slave
// Assumes: measurement inputs come from logic on I_CORE_CLK; SCL, SDA, tach are pins
// Notes: remote limits compare all 8 bits, signed
`timescale 1ns/1ps
`include "tfa_consts.svh"
module tfa_top
  import tfa_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
  parameter int unsigned STALL_BASE_CYC = `TFA_STALL_BASE_US * `TFA_CLK_MHZ
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_O,
  output logic O_SDA_OE,
  output logic O_ALERT_O,
  output logic O_ALERT_OE,
  input wire logic I_TACH,
  input wire logic I_CONV_BUSY,
  input wire logic I_DIODE_FAULT,
  input wire logic I_MEAS_VALID,
  input wire logic [7:0] I_LOCAL_TEMP,
  input wire logic [7:0] I_REMOTE_TEMP,
  input wire logic I_TACH_VALID,
  input wire logic [15:0] I_TACH_COUNT,
  output logic O_FAN_FULL,
  output logic O_FAN_LUT_MAX
);

  tfa_state_t q;
  tfa_state_t d;
  tfa_tach_if tach_if ();

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sda;
  logic ld_tx;
  logic wr_en;
  logic rd1;
  logic rd2;
  logic ara_done;
  logic pend;
  logic [7:0] txb;
  logic [7:0] cv1;
  logic [7:0] cv2;
  logic [7:0] av1;
  logic [7:0] av2;
  logic [4:0] tcond;
  logic [4:0] qual;
  logic [2:0] fq_need;

  // ---------------------------------------------------------------
  // stall watchdog
  // ---------------------------------------------------------------
  tfa_stall #(
    .BASE_CYC(STALL_BASE_CYC)
  ) tfa_stall_i (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_tach(I_TACH),
    .tach(tach_if.mon)
  );

  assign tach_if.periods = q.tachcfg[`TFA_TACHCFG_PER];

  // ---------------------------------------------------------------
  // register read view
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    logic [7:0] v;
    logic summ;
    summ = |(q.st1 & `TFA_ALERTABLE1) | |(q.st2 & `TFA_USED2);
    v = 8'h00;
    unique case (a)
      `TFA_ADR_STAT1: begin
        v = q.st1;
        v[`TFA_B1_BUSY] = I_CONV_BUSY;
        v[`TFA_B1_SUMMARY] = summ;
      end
      `TFA_ADR_STAT2: v = q.st2 & `TFA_USED2;
      `TFA_ADR_CFG1: v = q.cfg1;
      `TFA_ADR_LHI: v = q.lhi;
      `TFA_ADR_LLO: v = q.llo;
      `TFA_ADR_RHI: v = q.rhi;
      `TFA_ADR_RLO: v = q.rlo;
      `TFA_ADR_MASK1: v = q.mask1;
      `TFA_ADR_ROT: v = q.rot;
      `TFA_ADR_MASK2: v = q.mask2;
      `TFA_ADR_CFG2: v = q.cfg2;
      `TFA_ADR_HYST: v = q.hyst;
      `TFA_ADR_LOT: v = q.lot;
      `TFA_ADR_TACHCFG: v = q.tachcfg;
      `TFA_ADR_TLIM_LO: v = q.tlim_lo;
      `TFA_ADR_TLIM_HI: v = q.tlim_hi;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    ld_tx = 1'b0;
    wr_en = 1'b0;
    rd1 = 1'b0;
    rd2 = 1'b0;
    ara_done = 1'b0;
    txb = 8'h00;
    d.scl_s1 = I_SCL;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = I_SDA;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    sda = q.sda_s2;
    scl_rise = q.scl_s2 && !q.scl_s3;
    scl_fall = !q.scl_s2 && q.scl_s3;
    bus_start = q.scl_s2 && q.scl_s3 && q.sda_s3 && !q.sda_s2;
    bus_stop = q.scl_s2 && q.scl_s3 && !q.sda_s3 && q.sda_s2;

    // serial slave
    if (bus_stop) begin
      d.st = BUS_IDLE;
      d.sda_oe = 1'b0;
    end else if (bus_start) begin
      d.st = BUS_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
      d.ara = 1'b0;
    end else begin
      unique case (q.st)
        BUS_IDLE: d.sda_oe = 1'b0;
        BUS_ADDR, BUS_PTR, BUS_WDATA: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `TFA_BYTE_BITS) begin
            d.cnt = 4'h0;
            d.st = BUS_ACK;
            d.sda_oe = 1'b1;
            if (q.st == BUS_ADDR) begin
              if (q.sh[7:1] == DEV_ADDR) begin
                d.after = q.sh[0] ? BUS_TX : BUS_PTR;
              end else if (q.sh[7:1] == `TFA_ARA_ADDR && q.sh[0] && q.pin_oe &&
                           !q.cfg2[`TFA_CFG2_THERM_MODE]) begin
                d.after = BUS_TX;
                d.ara = 1'b1;
              end else begin
                d.st = BUS_IDLE;
                d.sda_oe = 1'b0;
              end
            end else if (q.st == BUS_PTR) begin
              d.ptr = q.sh;
              d.after = BUS_WDATA;
            end else begin
              wr_en = 1'b1;
              d.after = BUS_WDATA;
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            if (q.after == BUS_TX) begin
              ld_tx = 1'b1;
            end else begin
              d.st = q.after;
              d.cnt = 4'h0;
            end
          end
        end
        BUS_TX: begin
          if (scl_rise && q.ara && !q.sda_oe && !sda) begin
            // a lower address is still driving; step off the bus
            d.st = BUS_IDLE;
            d.ara = 1'b0;
          end else if (scl_fall) begin
            if (q.cnt == `TFA_BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.st = BUS_TXACK;
              ara_done = q.ara;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        BUS_TXACK: begin
          if (scl_rise) begin
            d.macked = ~sda;
          end else if (scl_fall) begin
            if (q.macked && !q.ara) begin
              ld_tx = 1'b1;
            end else begin
              d.st = BUS_IDLE;
              d.ara = 1'b0;
            end
          end
        end
      endcase
    end

    if (ld_tx) begin
      txb = q.ara ? {DEV_ADDR, 1'b1} : rd_val(q.ptr);
      rd1 = !q.ara && q.ptr == `TFA_ADR_STAT1;
      rd2 = !q.ara && q.ptr == `TFA_ADR_STAT2;
      d.sh = txb;
      d.sda_oe = ~txb[7];
      d.cnt = 4'h1;
      d.st = BUS_TX;
    end

    // register writes; status is read-only, unmapped offsets ignored
    if (wr_en) begin
      unique case (q.ptr)
        `TFA_ADR_CFG1: d.cfg1 = q.sh;
        `TFA_ADR_LHI: d.lhi = q.sh;
        `TFA_ADR_LLO: d.llo = q.sh;
        `TFA_ADR_RHI: d.rhi = q.sh;
        `TFA_ADR_RLO: d.rlo = q.sh;
        `TFA_ADR_MASK1: d.mask1 = q.sh;
        `TFA_ADR_ROT: d.rot = q.sh;
        `TFA_ADR_MASK2: d.mask2 = q.sh & `TFA_USED2;
        `TFA_ADR_CFG2: d.cfg2 = q.sh;
        `TFA_ADR_HYST: d.hyst = q.sh;
        `TFA_ADR_LOT: d.lot = q.sh;
        `TFA_ADR_TACHCFG: d.tachcfg = q.sh;
        `TFA_ADR_TLIM_LO: d.tlim_lo = q.sh;
        `TFA_ADR_TLIM_HI: d.tlim_hi = q.sh;
        default: d.cfg1 = q.cfg1;
      endcase
    end

    // limit comparisons on each finished measurement
    tcond[0] = tfa_gt(I_LOCAL_TEMP, q.lhi) || tfa_le(I_LOCAL_TEMP, q.llo);
    tcond[1] = tfa_gt(I_REMOTE_TEMP, q.rhi);
    tcond[2] = tfa_le(I_REMOTE_TEMP, q.rlo);
    tcond[3] = tfa_gt(I_REMOTE_TEMP, q.rot);
    tcond[4] = tfa_gt(I_LOCAL_TEMP, q.lot);
    if (I_MEAS_VALID) begin
      d.cond[4:0] = tcond;
      for (int i = 0; i < 5; i++) begin
        if (!tcond[i]) begin
          d.fq[i] = 3'h0;
        end else if (q.fq[i] != `TFA_FQ_MAX) begin
          d.fq[i] = q.fq[i] + 3'h1;
        end
      end
      // hysteresis keeps a hovering reading from toggling the pin
      if (tcond[4]) begin
        d.th_loc = 1'b1;
      end else if (tfa_at_release(I_LOCAL_TEMP, q.lot, q.hyst)) begin
        d.th_loc = 1'b0;
      end
      if (tcond[3]) begin
        d.th_rem = 1'b1;
      end else if (tfa_at_release(I_REMOTE_TEMP, q.rot, q.hyst)) begin
        d.th_rem = 1'b0;
      end
    end
    if (I_TACH_VALID) begin
      d.cond[5] = I_TACH_COUNT > {q.tlim_hi, q.tlim_lo};
    end

    // sticky status; a present cause always outranks the clear
    cv1 = 8'h00;
    cv1[`TFA_B1_LOCAL] = q.cond[0];
    cv1[`TFA_B1_RHI] = q.cond[1];
    cv1[`TFA_B1_RLO] = q.cond[2];
    cv1[`TFA_B1_FAULT] = I_DIODE_FAULT;
    cv1[`TFA_B1_ROT] = q.cond[3];
    cv1[`TFA_B1_FAN] = q.cond[5];
    cv2 = 8'h00;
    cv2[`TFA_B2_STALL] = tach_if.stalled;
    cv2[`TFA_B2_THERM] = q.th_loc || q.th_rem;
    cv2[`TFA_B2_LOT] = q.cond[4];
    d.st1 = rd1 ? cv1 : (q.st1 | cv1);
    d.st2 = rd2 ? cv2 : (q.st2 | cv2);

    // alert sources, temperature ones other than therm qualified by the fault queue, all gated by the masks
    fq_need = {1'b0, q.cfg1[`TFA_CFG1_FQ]} + 3'h1;
    for (int i = 0; i < 5; i++) begin
      qual[i] = q.fq[i] >= fq_need;
    end
    av1 = 8'h00;
    av1[`TFA_B1_LOCAL] = qual[0];
    av1[`TFA_B1_RHI] = qual[1];
    av1[`TFA_B1_RLO] = qual[2];
    av1[`TFA_B1_ROT] = qual[3];
    av1[`TFA_B1_FAN] = q.cond[5];
    av2 = cv2;
    av2[`TFA_B2_LOT] = qual[4];
    av1 = av1 & ~q.mask1 & `TFA_ALERTABLE1;
    av2 = av2 & ~q.mask2 & `TFA_USED2;
    pend = |av1 || |av2;
    d.alert = (rd1 || rd2 || ara_done) ? pend : (q.alert || pend);

    d.pin_oe = q.cfg2[`TFA_CFG2_THERM_MODE] ? (q.th_loc || q.th_rem) : q.alert;
    d.fan_full = (q.th_loc || q.th_rem) && q.cfg2[`TFA_CFG2_FULL];
    d.fan_lut = (q.th_loc || q.th_rem) && !q.cfg2[`TFA_CFG2_FULL] &&
                q.cfg2[`TFA_CFG2_LUTMAX];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      q <= '0;
      q.st <= BUS_IDLE;
      q.after <= BUS_IDLE;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
      q.cfg1 <= `TFA_RST_CFG1;
      q.lhi <= `TFA_RST_HI;
      q.llo <= `TFA_RST_LO;
      q.rhi <= `TFA_RST_HI;
      q.rlo <= `TFA_RST_LO;
      q.mask1 <= `TFA_RST_MASK;
      q.mask2 <= `TFA_RST_MASK;
      q.rot <= `TFA_RST_OT;
      q.lot <= `TFA_RST_OT;
      q.hyst <= `TFA_RST_HYST;
      q.cfg2 <= `TFA_RST_CFG2;
      q.tachcfg <= `TFA_RST_TACHCFG;
      q.tlim_lo <= `TFA_RST_TLIM;
      q.tlim_hi <= `TFA_RST_TLIM;
    end else begin
      q <= d;
    end
  end

  assign O_SDA_O = 1'b0;
  assign O_SDA_OE = q.sda_oe;
  assign O_ALERT_O = 1'b0;
  assign O_ALERT_OE = q.pin_oe;
  assign O_FAN_FULL = q.fan_full;
  assign O_FAN_LUT_MAX = q.fan_lut;

endmodule

/* File: dv/tfa_checker.sv */
// Purpose: port assertions for the alert logic
// Assumes: one clock domain, synchronous active-low reset
// Notes: age counters tie output edges to recent causes at the inputs
`timescale 1ns/1ps
module tfa_checker (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_MEAS_VALID,
  input wire logic O_SDA_O,
  input wire logic O_SDA_OE,
  input wire logic O_ALERT_O,
  input wire logic O_ALERT_OE,
  input wire logic O_FAN_FULL,
  input wire logic O_FAN_LUT_MAX
);
  // --------
  // cause ages
  // --------
  logic scl_q;
  logic [7:0] meas_q;
  logic [7:0] bus_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      scl_q <= 1'b1;
      meas_q <= 8'hFF;
      bus_q <= 8'hFF;
    end else begin
      scl_q <= I_SCL;
      meas_q <= I_MEAS_VALID ? 8'h00 : meas_q + {7'h00, meas_q != 8'hFF};
      bus_q <= (I_SCL != scl_q) ? 8'h00 : bus_q + {7'h00, bus_q != 8'hFF};
    end
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  a_sda_value_low: assert property (O_SDA_O == 1'b0)
    else $error("sda data value not low");
  a_alert_value_low: assert property (O_ALERT_O == 1'b0)
    else $error("alert data value not low");
  a_reset_quiet: assert property (disable iff (1'b0)
    !I_RST_N |=> !O_ALERT_OE && !O_SDA_OE && !O_FAN_FULL && !O_FAN_LUT_MAX)
    else $error("outputs active after reset");
  a_fan_one_mode: assert property (!(O_FAN_FULL && O_FAN_LUT_MAX))
    else $error("both fan forcing modes active");
  a_fan_from_meas: assert property ($rose(O_FAN_FULL) |-> meas_q < 8'h10)
    else $error("fan forced without a new reading");
  a_alert_release: assert property ($fell(O_ALERT_OE) |-> meas_q < 8'h10 || bus_q < 8'h10)
    else $error("alert released without read or reading");
  a_ack_hold: assert property ($rose(O_SDA_OE) |=> O_SDA_OE [*3])
    else $error("sda drive too short");
  a_sda_scl_low: assert property ($changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2))
    else $error("sda changed while clock high");
endmodule
bind tfa_top tfa_checker tfa_checker_i (
  .I_CORE_CLK(I_CORE_CLK),
  .I_RST_N(I_RST_N),
  .I_SCL(I_SCL),
  .I_MEAS_VALID(I_MEAS_VALID),
  .O_SDA_O(O_SDA_O),
  .O_SDA_OE(O_SDA_OE),
  .O_ALERT_O(O_ALERT_O),
  .O_ALERT_OE(O_ALERT_OE),
  .O_FAN_FULL(O_FAN_FULL),
  .O_FAN_LUT_MAX(O_FAN_LUT_MAX)
);

/* File: dv/tfa_host.sv */
// Purpose: serial bus host model for the alert logic
// Assumes: both lines pulled up; clock period 125 ns
// Notes: missing acks on register cycles are counted in misses
`timescale 1ns/1ps
`include "tfa_consts.svh"
module tfa_host #(
  parameter logic [6:0] DEV = 7'h15
) (
  input wire logic i_clk,
  input wire logic i_sda_dev_oe,
  output logic o_scl,
  output logic o_sda
);
  localparam realtime HALF = 62.5;
  logic scl_q = 1'b1;
  logic pull_q = 1'b0;
  int misses = 0;
  assign o_scl = scl_q;
  // released line floats to the pull-up
  assign o_sda = !(pull_q || i_sda_dev_oe);
  // --------
  // bus cycles
  // --------
  // data moves a quarter phase after the clock falls, clear of start detection
  task automatic start();
    // step off the core clock edge so no pin moves as it is sampled
    @(posedge i_clk);
    #1;
    #(HALF / 4) pull_q = 1'b0;
    #HALF scl_q = 1'b1;
    #HALF pull_q = 1'b1;
    #HALF scl_q = 1'b0;
  endtask
  task automatic stop();
    #(HALF / 4) pull_q = 1'b1;
    #HALF scl_q = 1'b1;
    #HALF pull_q = 1'b0;
    #HALF;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic [8:0] s;
    for (int i = 8; i >= 0; i--) begin
      #(HALF / 4) pull_q = (i > 0) ? !tx[i - 1] : 1'b0;
      #(HALF * 3 / 4) scl_q = 1'b1;
      #(HALF / 2) s[i] = o_sda;
      #(HALF / 2) scl_q = 1'b0;
    end
    rx = s[8:1];
    ack = !s[0];
  endtask
  task automatic send(input logic [7:0] tx);
    logic [7:0] r;
    logic a;
    xfer(tx, r, a);
    misses += int'(!a);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    start();
    send({DEV, 1'b0});
    send(adr);
    send(dat);
    stop();
  endtask
  task automatic rd(input logic [7:0] adr, output logic [7:0] dat);
    logic a;
    start();
    send({DEV, 1'b0});
    send(adr);
    start();
    send({DEV, 1'b1});
    xfer(8'hFF, dat, a);
    stop();
  endtask
  task automatic ara(input logic [7:0] rival, output logic [7:0] dat, output logic ack);
    logic a;
    dat = 8'h00;
    start();
    xfer({`TFA_ARA_ADDR, 1'b1}, dat, ack);
    if (ack) begin
      // zeros in rival are pulled by a second answering device; all ones means none
      xfer(rival, dat, a);
    end
    stop();
  endtask
endmodule

/* File: dv/tb_temp_fan_alert_logic.sv */
// Purpose: self-checking bench for status, mask, alert and over-temperature logic
// Assumes: stall base shortened to 200 clocks; tach period 80 clocks
// Notes: host model runs the serial pins, bench drives the measurement inputs
`timescale 1ns/1ps
`include "tfa_consts.svh"
module tb_temp_fan_alert_logic;
  localparam logic [6:0] DEV = 7'h15; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic sda;
  logic sda_oe;
  logic alert_oe;
  logic tach = 1'b0;
  logic run = 1'b1;
  logic busy = 1'b0;
  logic fault = 1'b0;
  logic mv = 1'b0;
  logic [7:0] loc = 8'h00;
  logic [7:0] rem = 8'h00;
  logic tv = 1'b0;
  logic [15:0] tc = 16'h0000;
  logic full;
  logic lut;
  int n_errors = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  always begin
    repeat (40) @(posedge clk);
    if (run) tach <= ~tach;
  end
  tfa_top #(.DEV_ADDR(DEV), .STALL_BASE_CYC(200)) tfa_top_i (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(),
    .O_SDA_OE(sda_oe), .O_ALERT_O(), .O_ALERT_OE(alert_oe), .I_TACH(tach),
    .I_CONV_BUSY(busy), .I_DIODE_FAULT(fault), .I_MEAS_VALID(mv), .I_LOCAL_TEMP(loc),
    .I_REMOTE_TEMP(rem), .I_TACH_VALID(tv), .I_TACH_COUNT(tc), .O_FAN_FULL(full),
    .O_FAN_LUT_MAX(lut));
  tfa_host #(.DEV(DEV)) tfa_host_i (.i_clk(clk), .i_sda_dev_oe(sda_oe), .o_scl(scl),
    .o_sda(sda));
  // --------
  // helpers
  // --------
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask
  task automatic rdk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    tfa_host_i.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic pin(input logic e);
    chk("alert pin", {7'h00, e}, {7'h00, alert_oe});
  endtask
  task automatic meas(input logic [7:0] l, input logic [7:0] r);
    @(posedge clk);
    loc <= l;
    rem <= r;
    mv <= 1'b1;
    @(posedge clk);
    mv <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic tach_meas(input logic [15:0] c);
    @(posedge clk);
    tc <= c;
    tv <= 1'b1;
    @(posedge clk);
    tv <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_reset();
    rdk(`TFA_ADR_LOT, 8'h64);
    rdk(`TFA_ADR_ROT, 8'h64);
    rdk(`TFA_ADR_HYST, 8'h0A);
    rdk(`TFA_ADR_CFG2, 8'h20);
    rdk(`TFA_ADR_TLIM_HI, 8'hFF);
    tfa_host_i.wr(`TFA_ADR_STAT1, 8'hFF);
    rdk(`TFA_ADR_STAT1, 8'h00);
    rdk(8'h7E, 8'h00);
    pin(1'b0);
    $display("test reset done");
  endtask
  task automatic t_limits();
    logic [7:0] l [5] = '{8'h55, 8'h56, 8'h00, 8'h20, 8'h20};
    logic [7:0] r [5] = '{8'h20, 8'h20, 8'h20, 8'h56, 8'h00};
    logic [7:0] e [5] = '{8'h00, 8'h60, 8'h60, 8'h30, 8'h28};
    for (int i = 0; i < 5; i++) begin
      meas(l[i], r[i]);
      pin(e[i] != 8'h00);
      meas(8'h20, 8'h20);
      pin(e[i] != 8'h00);
      rdk(`TFA_ADR_STAT1, e[i]);
      rdk(`TFA_ADR_STAT1, 8'h00);
      pin(1'b0);
    end
    @(posedge clk);
    busy <= 1'b1;
    fault <= 1'b1;
    rdk(`TFA_ADR_STAT1, 8'h84);
    pin(1'b0);
    @(posedge clk);
    busy <= 1'b0;
    fault <= 1'b0;
    rdk(`TFA_ADR_STAT1, 8'h04);
    rdk(`TFA_ADR_STAT1, 8'h00);
    $display("test limits done");
  endtask
  task automatic t_fan();
    tfa_host_i.wr(`TFA_ADR_TLIM_HI, 8'h10);
    tfa_host_i.wr(`TFA_ADR_TLIM_LO, 8'h00);
    tfa_host_i.wr(`TFA_ADR_MASK1, 8'hA5);
    tach_meas(16'h1000);
    rdk(`TFA_ADR_STAT1, 8'h00);
    tach_meas(16'h1001);
    pin(1'b0);
    rdk(`TFA_ADR_STAT1, 8'h21);
    tfa_host_i.wr(`TFA_ADR_MASK1, 8'hA4);
    tach_meas(16'h1001);
    pin(1'b1);
    tach_meas(16'h0100);
    rdk(`TFA_ADR_STAT1, 8'h21);
    pin(1'b0);
    $display("test fan done");
  endtask
  task automatic t_stall();
    tfa_host_i.wr(`TFA_ADR_MASK2, 8'hFF);
    rdk(`TFA_ADR_MASK2, 8'hD0);
    for (int k = 0; k < 2; k++) begin
      run = 1'b0;
      repeat (300) @(posedge clk);
      pin(1'b0);
      repeat (200) @(posedge clk);
      pin(k == 1);
      run <= 1'b1;
      rdk(`TFA_ADR_STAT1, 8'h20);
      rdk(`TFA_ADR_STAT2, 8'h80);
      pin(1'b0);
      tfa_host_i.wr(`TFA_ADR_MASK2, 8'h00);
      tfa_host_i.wr(`TFA_ADR_TACHCFG, 8'h04);
    end
    $display("test stall done");
  endtask
  task automatic t_ara();
    logic [7:0] d;
    logic a;
    tfa_host_i.wr(`TFA_ADR_CFG1, 8'h01);
    meas(8'h56, 8'h20);
    pin(1'b0);
    meas(8'h56, 8'h20);
    pin(1'b1);
    // a lower-address rival answers too; ours must step off and keep the line low
    tfa_host_i.ara({7'h12, 1'b1}, d, a);
    chk("ara lost", {7'h12, 1'b1}, d);
    pin(1'b1);
    tfa_host_i.ara(8'hFF, d, a);
    chk("ara ack", 8'h01, {7'h00, a});
    chk("ara addr", {DEV, 1'b1}, d);
    pin(1'b1);
    meas(8'h20, 8'h20);
    tfa_host_i.ara(8'hFF, d, a);
    chk("ara again", 8'h01, {7'h00, a});
    pin(1'b0);
    tfa_host_i.ara(8'hFF, d, a);
    chk("ara refused", 8'h00, {7'h00, a});
    rdk(`TFA_ADR_STAT1, 8'h60);
    tfa_host_i.wr(`TFA_ADR_CFG1, 8'h00);
    $display("test ara done");
  endtask
  task automatic t_therm();
    tfa_host_i.wr(`TFA_ADR_CFG2, 8'hA0);
    meas(8'h65, 8'h20);
    pin(1'b1);
    chk("fan full", 8'h01, {7'h00, full});
    meas(8'h5B, 8'h20);
    pin(1'b1);
    meas(8'h5A, 8'h20);
    pin(1'b0);
    tfa_host_i.wr(`TFA_ADR_HYST, 8'h00);
    meas(8'h65, 8'h20);
    meas(8'h64, 8'h20);
    pin(1'b0);
    tfa_host_i.wr(`TFA_ADR_CFG2, 8'h90);
    meas(8'h65, 8'h20);
    chk("fan lut", 8'h01, {6'h00, full, lut});
    meas(8'h20, 8'h20);
    rdk(`TFA_ADR_STAT2, 8'h50);
    tfa_host_i.wr(`TFA_ADR_CFG2, 8'h20);
    rdk(`TFA_ADR_STAT1, 8'h60);
    pin(1'b0);
    $display("test therm done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_limits();
    t_fan();
    t_stall();
    t_ara();
    t_therm();
    chk("ack misses", 8'h00, tfa_host_i.misses[7:0]);
    summarize();
  end
  initial begin
    #450000;
    n_errors++;
    summarize();
  end
endmodule
